//--- inc/mfs_pkg.sv
// Purpose: Shared constants for the motor fault supervisor
// Assumes: 40 MHz system clock, APB register access with 32-bit data
// Notes: Sensor and command words are unsigned 16-bit magnitudes
package mfs_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_MASK = 12'h008;
  localparam logic [11:0] OFS_ERROR = 12'h00c;
  localparam logic [11:0] OFS_OCLIM = 12'h010;
  localparam logic [11:0] OFS_OTLIM = 12'h014;
  localparam logic [11:0] OFS_DERLIM = 12'h018;
  localparam logic [11:0] OFS_SPDMAX = 12'h01c;
  localparam logic [11:0] OFS_SPDEXT = 12'h020;
  localparam logic [11:0] OFS_VSUPMAX = 12'h024;
  localparam logic [11:0] OFS_TIMEOUT = 12'h028;
  localparam logic [11:0] OFS_STATE = 12'h02c;
  // CTRL fields
  localparam int CTRL_OC_LATCH = 0;
  localparam int CTRL_OT_LATCH = 1;
  localparam int CTRL_ARM = 2;
  localparam int CTRL_DISARM = 3;
  // STATUS, MASK event bits
  localparam int EV_OC = 0;
  localparam int EV_OT = 1;
  localparam int EV_SPEED = 2;
  localparam int EV_REGEN = 3;
  localparam int EV_TIMEOUT = 4;
  localparam int EV_WDOG = 5;
  localparam int EV_DERATE = 6;
  localparam int EV_BRAKE = 7;
  localparam int EV_W = 8;
  // ERROR fields, write one to clear
  localparam int ERR_OC = 0;
  localparam int ERR_OT = 1;
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] OCLIM_RST = 16'h8000;
  localparam logic [15:0] OTLIM_RST = 16'h0c00;
  localparam logic [15:0] DERLIM_RST = 16'h0a00;
  localparam logic [15:0] SPDMAX_RST = 16'h4000;
  localparam logic [15:0] SPDEXT_RST = 16'h6000;
  localparam logic [15:0] VSUPMAX_RST = 16'hc000;
  localparam logic [31:0] TIMEOUT_RST = 32'h0000_0000;
  // Limiter gains as left shifts of the excess
  localparam logic [3:0] CUR_SH = 4'h2;
  localparam logic [3:0] TMP_SH = 4'h3;
  localparam logic [3:0] SPD_SH = 4'h1;
  localparam logic [3:0] REG_SH = 4'h4;
  // Watchdog window
  localparam int CLK_MHZ = 40;
  localparam int WDOG_TIME_US = 100000;
  localparam int WDOG_CYCLES = WDOG_TIME_US * CLK_MHZ;
endpackage : mfs_pkg

//--- rtl/mfs_supervisor.sv
// Purpose: Protection supervisor gating and limiting the motor drive output
// Assumes: All sensor inputs synchronous to clk; APB slave, no wait state
// Notes: Driven outputs are registered, so reactions land one edge later, irq two edges later
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/10ps
module mfs_supervisor #(
  parameter int WDOG_CYC = mfs_pkg::WDOG_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] cmdVolt,
  input wire logic cmdValid,
  input wire logic [15:0] predCurrent,
  input wire logic [15:0] currentMeas,
  input wire logic [15:0] ctrlTemp,
  input wire logic [15:0] coilTempEst,
  input wire logic [15:0] speedMeas,
  input wire logic [15:0] supplyVolt,
  input wire logic progressBeat,
  output logic [15:0] driveVolt,
  output logic gateEnable,
  output logic phaseShort,
  output logic coastMode,
  output logic derate,
  output logic armed,
  output logic ctrlResetReq,
  output logic irq
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RUN = 5'h02,
    ST_COAST = 5'h04,
    ST_OFF = 5'h08,
    ST_BRAKE = 5'h10
  } mfs_state_type;

  // Amount by which a exceeds b, zero otherwise
  function automatic logic [15:0] mfsOver(input logic [15:0] a, input logic [15:0] b);
    mfsOver = (a > b) ? a - b : 16'h0;
  endfunction : mfsOver

  // Reduce v by a shifted excess, saturating at zero
  function automatic logic [15:0] mfsCut(input logic [15:0] v, input logic [15:0] over,
                                         input logic [3:0] sh);
    logic [31:0] cut;
    cut = {16'h0, over} << sh;
    if (cut >= {16'h0, v})
      mfsCut = 16'h0;
    else
      mfsCut = v - cut[15:0];
  endfunction : mfsCut

  mfs_state_type state_ff, nxt_state;
  logic [1:0] ctrl_ff;
  logic [mfs_pkg::EV_W-1:0] status_ff, mask_ff, events;
  logic [1:0] error_ff;
  logic [15:0] ocLim_ff, otLim_ff, derLim_ff, spdMax_ff, spdExt_ff, vsupMax_ff;
  logic [31:0] timeout_ff, toCount_ff, wdCount_ff;
  logic timedOut_ff, armed_ff, wdFire_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, irq_ff;
  logic [15:0] driveVolt_ff, nxt_driveVolt;
  logic gateEnable_ff, phaseShort_ff, coastMode_ff, derate_ff;
  logic [15:0] tempMax, v1, v2, v3, v4;
  logic ocFault, otFault, derateCond, overSpeed, extreme, regenHigh, wdFire;
  logic ocOff, otOff, runOk, apbWr, apbRd, isStatus;
  logic [31:0] rdVal;
  logic rdMapped;

  // Fault detection from the live measurements
  assign tempMax = (ctrlTemp > coilTempEst) ? ctrlTemp : coilTempEst;
  assign ocFault = currentMeas > ocLim_ff;
  assign otFault = tempMax > otLim_ff;
  assign derateCond = tempMax >= derLim_ff;
  assign overSpeed = speedMeas > spdMax_ff;
  assign extreme = speedMeas > spdExt_ff;
  assign regenHigh = supplyVolt > vsupMax_ff;
  assign wdFire = wdCount_ff >= 32'(WDOG_CYC - 1);
  // Latched mode keeps the drive off until the flag is cleared
  assign ocOff = ocFault | (ctrl_ff[mfs_pkg::CTRL_OC_LATCH] & error_ff[mfs_pkg::ERR_OC]);
  assign otOff = otFault | (ctrl_ff[mfs_pkg::CTRL_OT_LATCH] & error_ff[mfs_pkg::ERR_OT]);
  assign runOk = armed_ff & ~wdFire & ~ocOff & ~otOff & ~timedOut_ff & ~extreme;

  // Voltage limiter chain; each stage only lowers the command
  assign v1 = mfsCut(cmdVolt, mfsOver(predCurrent, ocLim_ff), mfs_pkg::CUR_SH);
  assign v2 = mfsCut(v1, mfsOver(tempMax, derLim_ff), mfs_pkg::TMP_SH);
  assign v3 = mfsCut(v2, mfsOver(speedMeas, spdMax_ff), mfs_pkg::SPD_SH);
  assign v4 = mfsCut(v3, mfsOver(supplyVolt, vsupMax_ff), mfs_pkg::REG_SH);

  // Drive mode priority: reboot, unarmed, shutdown, coast, brake
  always_comb
  begin
    if (wdFire || !armed_ff)
      nxt_state = ST_IDLE;
    else if (ocOff || otOff)
      nxt_state = ST_OFF;
    else if (timedOut_ff)
      nxt_state = ST_COAST;
    else if (extreme)
      nxt_state = ST_BRAKE;
    else
      nxt_state = ST_RUN;
    nxt_driveVolt = (nxt_state == ST_RUN) ? v4 : 16'h0;
  end

  // Mode register and its registered outputs
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_IDLE;
      driveVolt_ff <= 16'h0;
      gateEnable_ff <= 1'b0;
      phaseShort_ff <= 1'b0;
      coastMode_ff <= 1'b1;
      derate_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      driveVolt_ff <= nxt_driveVolt;
      gateEnable_ff <= (nxt_state == ST_RUN) || (nxt_state == ST_BRAKE);
      phaseShort_ff <= nxt_state == ST_BRAKE;
      coastMode_ff <= (nxt_state == ST_COAST) || (nxt_state == ST_IDLE);
      derate_ff <= derateCond;
    end
  end

  // Arming; the watchdog reboot always drops it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      armed_ff <= 1'b0;
    else if (wdFire)
      armed_ff <= 1'b0;
    else if (apbWr && paddr == mfs_pkg::OFS_CTRL && pwdata[mfs_pkg::CTRL_DISARM])
      armed_ff <= 1'b0;
    else if (apbWr && paddr == mfs_pkg::OFS_CTRL && pwdata[mfs_pkg::CTRL_ARM])
      armed_ff <= 1'b1;
  end

  // Command timeout; a zero interval disables it
  always_ff @(posedge clk)
  begin
    if (!reset_n || wdFire)
    begin
      toCount_ff <= 32'h0;
      timedOut_ff <= 1'b0;
    end
    else if (cmdValid)
    begin
      toCount_ff <= 32'h0;
      timedOut_ff <= 1'b0;
    end
    else if (timeout_ff != 32'h0 && toCount_ff >= timeout_ff - 32'h1)
      timedOut_ff <= 1'b1;
    else
      toCount_ff <= toCount_ff + 32'h1;
  end

  // Watchdog counts cycles without a progress beat
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wdCount_ff <= 32'h0;
      wdFire_ff <= 1'b0;
    end
    else
    begin
      wdCount_ff <= (progressBeat || wdFire) ? 32'h0 : wdCount_ff + 32'h1;
      wdFire_ff <= wdFire;
    end
  end

  // APB decode; no wait state, yet read data comes from a flop set in setup
  assign apbWr = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  assign apbRd = psel & penable & pready_ff & ~pwrite;
  assign isStatus = apbRd && paddr == mfs_pkg::OFS_STATUS && !pslverr_ff;

  always_comb
  begin
    rdMapped = 1'b1;
    rdVal = 32'h0;
    if (paddr == mfs_pkg::OFS_CTRL)
      rdVal = {30'h0, ctrl_ff};
    else if (paddr == mfs_pkg::OFS_STATUS)
      rdVal = {24'h0, status_ff};
    else if (paddr == mfs_pkg::OFS_MASK)
      rdVal = {24'h0, mask_ff};
    else if (paddr == mfs_pkg::OFS_ERROR)
      rdVal = {30'h0, error_ff};
    else if (paddr == mfs_pkg::OFS_OCLIM)
      rdVal = {16'h0, ocLim_ff};
    else if (paddr == mfs_pkg::OFS_OTLIM)
      rdVal = {16'h0, otLim_ff};
    else if (paddr == mfs_pkg::OFS_DERLIM)
      rdVal = {16'h0, derLim_ff};
    else if (paddr == mfs_pkg::OFS_SPDMAX)
      rdVal = {16'h0, spdMax_ff};
    else if (paddr == mfs_pkg::OFS_SPDEXT)
      rdVal = {16'h0, spdExt_ff};
    else if (paddr == mfs_pkg::OFS_VSUPMAX)
      rdVal = {16'h0, vsupMax_ff};
    else if (paddr == mfs_pkg::OFS_TIMEOUT)
      rdVal = timeout_ff;
    else if (paddr == mfs_pkg::OFS_STATE)
      rdVal = {24'h0, timedOut_ff, armed_ff, derate_ff, state_ff};
    else
      rdMapped = 1'b0;
  end

  // Answer is prepared in the setup cycle and shown during access
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end
    else
    begin
      pready_ff <= psel & ~penable;
      if (psel && !penable)
      begin
        pslverr_ff <= ~rdMapped;
        prdata_ff <= pwrite ? 32'h0 : rdVal;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_ff <= mfs_pkg::CTRL_RST;
      mask_ff <= '0;
      ocLim_ff <= mfs_pkg::OCLIM_RST;
      otLim_ff <= mfs_pkg::OTLIM_RST;
      derLim_ff <= mfs_pkg::DERLIM_RST;
      spdMax_ff <= mfs_pkg::SPDMAX_RST;
      spdExt_ff <= mfs_pkg::SPDEXT_RST;
      vsupMax_ff <= mfs_pkg::VSUPMAX_RST;
      timeout_ff <= mfs_pkg::TIMEOUT_RST;
    end
    else if (apbWr)
    begin
      if (paddr == mfs_pkg::OFS_CTRL)
        ctrl_ff <= pwdata[1:0];
      else if (paddr == mfs_pkg::OFS_MASK)
        mask_ff <= pwdata[mfs_pkg::EV_W-1:0];
      else if (paddr == mfs_pkg::OFS_OCLIM)
        ocLim_ff <= pwdata[15:0];
      else if (paddr == mfs_pkg::OFS_OTLIM)
        otLim_ff <= pwdata[15:0];
      else if (paddr == mfs_pkg::OFS_DERLIM)
        derLim_ff <= pwdata[15:0];
      else if (paddr == mfs_pkg::OFS_SPDMAX)
        spdMax_ff <= pwdata[15:0];
      else if (paddr == mfs_pkg::OFS_SPDEXT)
        spdExt_ff <= pwdata[15:0];
      else if (paddr == mfs_pkg::OFS_VSUPMAX)
        vsupMax_ff <= pwdata[15:0];
      else if (paddr == mfs_pkg::OFS_TIMEOUT)
        timeout_ff <= pwdata;
    end
  end

  // Error flags: set while faulted, so a clear cannot win over the fault
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      error_ff <= 2'h0;
    else
    begin
      if (ocFault)
        error_ff[mfs_pkg::ERR_OC] <= 1'b1;
      else if (apbWr && paddr == mfs_pkg::OFS_ERROR && pwdata[mfs_pkg::ERR_OC])
        error_ff[mfs_pkg::ERR_OC] <= 1'b0;
      if (otFault)
        error_ff[mfs_pkg::ERR_OT] <= 1'b1;
      else if (apbWr && paddr == mfs_pkg::OFS_ERROR && pwdata[mfs_pkg::ERR_OT])
        error_ff[mfs_pkg::ERR_OT] <= 1'b0;
    end
  end

  // Interrupt events; read clears only the bits that were returned
  assign events = {phaseShort_ff, derateCond, wdFire, timedOut_ff, regenHigh, overSpeed,
                   otFault, ocFault};

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      status_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (isStatus)
        status_ff <= (status_ff & ~prdata_ff[mfs_pkg::EV_W-1:0]) | events;
      else
        status_ff <= status_ff | events;
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign driveVolt = driveVolt_ff;
  assign gateEnable = gateEnable_ff;
  assign phaseShort = phaseShort_ff;
  assign coastMode = coastMode_ff;
  assign derate = derate_ff;
  assign armed = armed_ff;
  assign ctrlResetReq = wdFire_ff;
  assign irq = irq_ff;

  // Checks on the protection behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  pred_clamp_a: assert property ((predCurrent > ocLim_ff && cmdVolt != 16'h0) |=>
    driveVolt_ff < $past(cmdVolt)) else $error("output not clamped on predicted current");
  oc_gates_off_a: assert property (ocFault |=> !gateEnable_ff)
    else $error("gates on during over-current");
  oc_latch_hold_a: assert property ((ctrl_ff[0] && error_ff[0]) |=> !gateEnable_ff)
    else $error("latched over-current released drive");
  run_recover_a: assert property (runOk |=> gateEnable_ff && !coastMode_ff)
    else $error("drive not re-enabled with faults gone");
  derate_track_a: assert property (derateCond |=> derate_ff)
    else $error("derate not entered");
  derate_exit_a: assert property (!derateCond |=> !derate_ff)
    else $error("derate not left");
  coil_derate_a: assert property ((coilTempEst >= derLim_ff && cmdVolt != 16'h0 &&
    coilTempEst > derLim_ff) |=> driveVolt_ff < $past(cmdVolt)) else $error("coil derate lost");
  ot_gates_off_a: assert property (otFault |=> !gateEnable_ff)
    else $error("gates on during over-temperature");
  ot_latch_hold_a: assert property ((ctrl_ff[1] && error_ff[1]) |=> !gateEnable_ff)
    else $error("latched over-temperature released drive");
  speed_cut_a: assert property ((overSpeed && cmdVolt != 16'h0) |=>
    driveVolt_ff < $past(cmdVolt)) else $error("over-speed not limited");
  brake_short_a: assert property ((extreme && armed_ff && !wdFire && !ocOff && !otOff &&
    !timedOut_ff) |=> phaseShort_ff && gateEnable_ff) else $error("no brake on extreme speed");
  regen_cut_a: assert property ((regenHigh && cmdVolt != 16'h0) |=>
    driveVolt_ff < $past(cmdVolt)) else $error("regen not limited");
  timeout_coast_a: assert property (timedOut_ff |=> !gateEnable_ff ##0 driveVolt_ff == 16'h0)
    else $error("drive active after timeout");
  timeout_clear_a: assert property (cmdValid |=> !timedOut_ff)
    else $error("timeout kept after new command");
  wdog_reboot_a: assert property (wdFire |=> ctrlResetReq && !armed_ff ##1 !ctrlResetReq)
    else $error("watchdog reboot wrong");
  err_sticky_a: assert property (ocFault |=> error_ff[0])
    else $error("error flag not held during fault");

  oc_trip_c: cover property (ocFault ##1 !ocFault ##1 gateEnable_ff);
  brake_c: cover property (phaseShort_ff);
  timeout_resume_c: cover property (timedOut_ff ##1 cmdValid ##2 gateEnable_ff);
  wdog_c: cover property (ctrlResetReq);
endmodule : mfs_supervisor

//--- bench/mfs_host_model.sv
// Purpose: Host-side model that issues APB transfers and motor command messages
// Assumes: One clock; the slave answers through pready
// Notes: Command pulses run in the background while cmdOn is set
`timescale 1ns/10ps
module mfs_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic cmdValid
);
  logic cmdOn;
  int gap;

  // Idle bus at time zero, commands off until the bench enables them
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cmdValid = 1'b0;
    cmdOn = 1'b0;
    gap = 0;
  end

  // One message every 8 cycles; stopping it lets the command timeout expire
  always @(posedge clk)
  begin
    gap <= (gap == 7) ? 0 : gap + 1;
    cmdValid <= cmdOn && (gap == 0);
  end

  // Setup, then access held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No wait limit here; only the bench's cycle ceiling ends a hung access
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : mfs_host_model

//--- bench/tb.sv
// Purpose: Self-checking bench for the motor fault supervisor
// Assumes: Watchdog shortened to 64 cycles; reference limiter written from the rules
// Notes: Sensor inputs change right after a rising edge by non-blocking assignment
`timescale 1ns/10ps
module tb;
  localparam int WD = 64;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, cmdValid, progressBeat;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] cmdVolt, predCurrent, currentMeas, ctrlTemp, coilTempEst, speedMeas, supplyVolt;
  logic [15:0] driveVolt;
  logic gateEnable, phaseShort, coastMode, derate, armed, ctrlResetReq, irq, beatOn, err, hit;
  int errCount, nCompared, cyc, ex, cmd;
  logic [11:0] ra [9] = '{mfs_pkg::OFS_CTRL, mfs_pkg::OFS_OCLIM, mfs_pkg::OFS_OTLIM,
    mfs_pkg::OFS_DERLIM, mfs_pkg::OFS_SPDMAX, mfs_pkg::OFS_SPDEXT, mfs_pkg::OFS_VSUPMAX,
    mfs_pkg::OFS_TIMEOUT, mfs_pkg::OFS_STATE};
  logic [31:0] rv [9] = '{32'h0, {16'h0, mfs_pkg::OCLIM_RST}, {16'h0, mfs_pkg::OTLIM_RST},
    {16'h0, mfs_pkg::DERLIM_RST}, {16'h0, mfs_pkg::SPDMAX_RST}, {16'h0, mfs_pkg::SPDEXT_RST},
    {16'h0, mfs_pkg::VSUPMAX_RST}, mfs_pkg::TIMEOUT_RST, 32'h1};

  mfs_supervisor #(.WDOG_CYC(WD)) mfs_supervisor_inst (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmdVolt(cmdVolt),
    .cmdValid(cmdValid), .predCurrent(predCurrent), .currentMeas(currentMeas),
    .ctrlTemp(ctrlTemp), .coilTempEst(coilTempEst), .speedMeas(speedMeas),
    .supplyVolt(supplyVolt), .progressBeat(progressBeat), .driveVolt(driveVolt),
    .gateEnable(gateEnable), .phaseShort(phaseShort), .coastMode(coastMode),
    .derate(derate), .armed(armed), .ctrlResetReq(ctrlResetReq), .irq(irq));
  mfs_host_model host_inst (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmdValid(cmdValid));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Progress beats keep the watchdog quiet; the cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    progressBeat <= beatOn && (cyc % 16 == 0);
    if (cyc > 20000)
    begin
      errCount++;
      results();
    end
  end

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed);
  endfunction : rnd

  // Reference limiter: command minus shifted excess, floored at zero
  function automatic int lim(int c, int x, int sh);
    int v;
    v = c - (x << sh);
    return (v < 0) ? 0 : v;
  endfunction : lim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      errCount++;
      $display("CHECK FAILED %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_inst.xfer(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdx(input logic [11:0] a);
    host_inst.xfer(1'b0, a, 32'h0, rd, err);
  endtask : rdx

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle

  // Quiet sensor values well inside every limit
  task automatic nominal();
    predCurrent <= 16'h1000;
    currentMeas <= 16'h1000;
    ctrlTemp <= 16'h0100;
    coilTempEst <= 16'h0100;
    speedMeas <= 16'h1000;
    supplyVolt <= 16'h8000;
  endtask : nominal

  task automatic results();
    $display("mismatches %0d comparisons %0d", errCount, nCompared);
    if (errCount == 0 && nCompared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  initial
  begin
    errCount = 0;
    nCompared = 0;
    cyc = 0;
    seed = 32'd91330;
    reset_n = 1'b0;
    beatOn = 1'b1;
    cmdVolt = 16'h0000;
    progressBeat = 1'b0;
    nominal();
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    host_inst.cmdOn <= 1'b1;
    settle();
    chk({gateEnable, coastMode, armed}, 32'h2);
    for (int i = 0; i < 9; i++)
    begin
      rdx(ra[i]);
      chk(rd, rv[i]);
    end
    wr(12'h0f0, 32'hffff_ffff);
    chk(err, 1'b1);
    rdx(12'h0f0);
    chk({err, rd}, {1'b1, 32'h0});
    wr(mfs_pkg::OFS_CTRL, 32'h1 << mfs_pkg::CTRL_ARM);
    settle();
    chk({armed, gateEnable, coastMode}, 32'h6);
    // Each limiter alone, with a random command and a random excess
    for (int k = 0; k < 5; k++)
    begin
      cmd = rnd() & 32'hffff;
      ex = (rnd() & 32'hff) + 1;
      @(posedge clk);
      cmdVolt <= cmd[15:0];
      case (k)
        0: predCurrent <= mfs_pkg::OCLIM_RST + ex[15:0];
        1: ctrlTemp <= mfs_pkg::DERLIM_RST + ex[15:0];
        2: coilTempEst <= mfs_pkg::DERLIM_RST + ex[15:0];
        3: speedMeas <= mfs_pkg::SPDMAX_RST + ex[15:0];
        default: supplyVolt <= mfs_pkg::VSUPMAX_RST + ex[15:0];
      endcase
      settle();
      chk(driveVolt, lim(cmd, ex, (k == 0) ? 2 : (k < 3) ? 3 : (k == 3) ? 1 : 4));
      chk(derate, (k == 1 || k == 2));
      nominal();
      settle();
      chk({derate, driveVolt}, cmd);
    end
    // Over-current then over-temperature, non-latching and latching
    for (int k = 0; k < 2; k++)
    begin
      wr(mfs_pkg::OFS_CTRL, 32'h0);
      for (int l = 0; l < 2; l++)
      begin
        if (k == 0)
          currentMeas <= 16'h9000;
        else
          ctrlTemp <= 16'h0d00;
        settle();
        chk({gateEnable, driveVolt}, 32'h0);
        wr(mfs_pkg::OFS_ERROR, 32'h1 << k);
        rdx(mfs_pkg::OFS_ERROR);
        chk(rd[k], 1'b1);
        nominal();
        settle();
        chk(gateEnable, l == 0);
        wr(mfs_pkg::OFS_ERROR, 32'h1 << k);
        settle();
        chk(gateEnable, 1'b1);
        wr(mfs_pkg::OFS_CTRL, 32'h1 << k);
      end
    end
    // Interrupt masked, unmasked, then cleared by a status read
    wr(mfs_pkg::OFS_MASK, 32'h0);
    currentMeas <= 16'h9000;
    settle();
    chk(irq, 1'b0);
    wr(mfs_pkg::OFS_MASK, 32'h1 << mfs_pkg::EV_OC);
    settle();
    chk(irq, 1'b1);
    nominal();
    wr(mfs_pkg::OFS_ERROR, 32'h3);
    rdx(mfs_pkg::OFS_STATUS);
    chk(rd[mfs_pkg::EV_OC], 1'b1);
    settle();
    chk(irq, 1'b0);
    speedMeas <= 16'h7000;
    settle();
    chk({phaseShort, gateEnable}, 32'h3);
    nominal();
    // Command timeout: coast while silent, run again on the next message
    wr(mfs_pkg::OFS_TIMEOUT, 32'd40);
    host_inst.cmdOn <= 1'b0;
    repeat (60) @(posedge clk);
    chk({coastMode, armed, driveVolt}, {2'b11, 16'h0});
    host_inst.cmdOn <= 1'b1;
    repeat (12) @(posedge clk);
    chk(coastMode, 1'b0);
    // Watchdog: stop progress, expect one reboot request and an unarmed drive
    beatOn <= 1'b0;
    hit = 1'b0;
    for (int i = 0; i < 200 && !hit; i++)
    begin
      @(posedge clk);
      hit = (ctrlResetReq === 1'b1);
    end
    chk(hit, 1'b1);
    beatOn <= 1'b1;
    settle();
    chk({armed, gateEnable}, 32'h0);
    wr(mfs_pkg::OFS_CTRL, 32'h1 << mfs_pkg::CTRL_ARM);
    settle();
    chk(armed, 1'b1);
    rdx(mfs_pkg::OFS_STATE);
    chk(rd, 32'h42);
    // Disarm pulse drops the drive back to coast
    wr(mfs_pkg::OFS_CTRL, 32'h1 << mfs_pkg::CTRL_DISARM);
    settle();
    chk({armed, gateEnable, coastMode}, 32'h1);
    results();
  end
endmodule : tb
